/* File: dmut_map.svh */
// Register indices, field positions, reset values and counts of the dual up timers
`ifndef DMUT_MAP_SVH
`define DMUT_MAP_SVH

// ================================================================
// Register indices (byte address is four times the index)
`define DMUT_IDX_CTRL_STATUS 8'h88
`define DMUT_IDX_MODE_SEL 8'h89
`define DMUT_IDX_FIRST_LOW 8'h8A
`define DMUT_IDX_SECOND_LOW 8'h8B
`define DMUT_IDX_FIRST_HIGH 8'h8C
`define DMUT_IDX_SECOND_HIGH 8'h8D
`define DMUT_IDX_IRQ_ENABLE 8'hA8
`define DMUT_IDX_PRESCALER 8'hE7

// ================================================================
// Field positions
`define DMUT_SECOND_FLAG_BIT 7
`define DMUT_SECOND_RUN_BIT 6
`define DMUT_FIRST_FLAG_BIT 5
`define DMUT_FIRST_RUN_BIT 4
`define DMUT_SECOND_GATE_BIT 7
`define DMUT_SECOND_CSEL_BIT 6
`define DMUT_SECOND_MODE_LSB 4
`define DMUT_FIRST_GATE_BIT 3
`define DMUT_FIRST_CSEL_BIT 2
`define DMUT_FIRST_MODE_LSB 0
`define DMUT_FIRST_PRESC_LSB 4
`define DMUT_SECOND_PRESC_LSB 0
`define DMUT_GLOBAL_IE_BIT 7
`define DMUT_SECOND_IE_BIT 3
`define DMUT_FIRST_IE_BIT 1

// ================================================================
// Mode codes, reset values, counts, bus answers
`define DMUT_MODE_13 2'h0
`define DMUT_MODE_16 2'h1
`define DMUT_MODE_RELOAD 2'h2
`define DMUT_MODE_SPLIT 2'h3
`define DMUT_CNT_RST 8'h00
`define DMUT_CPU_PRESCALE 12
`define DMUT_RESP_OKAY 2'h0
`define DMUT_RESP_SLVERR 2'h2

`endif

/* File: dmut_pkg.sv */
// Types and shared functions of the dual up timers
package dmut_pkg;
`include "dmut_map.svh"

    // ================================================================
    // Bus handshake phases, Gray coded from DMUT_IDLE through DMUT_RESP; the step back to DMUT_IDLE flips both bits
    typedef enum logic [1:0] {
        DMUT_IDLE = 2'h0,
        DMUT_TAKE = 2'h1,
        DMUT_RESP = 2'h3
    } dmut_bus_type;

    typedef struct packed {
        logic ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } dmut_count_type;

    typedef struct packed {
        logic tf1;
        logic tr1;
        logic tf0;
        logic tr0;
        logic [7:0] timer_mode_select;
        logic [2:0] presc0;
        logic [2:0] presc1;
        logic [7:0] th0;
        logic [7:0] tl0;
        logic [7:0] th1;
        logic [7:0] tl1;
        logic global_irq_enable;
        logic et1;
        logic et0;
        logic irq0;
        logic irq1;
        dmut_bus_type wst;
        dmut_bus_type rst;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } dmut_state_type;

    // ================================================================
    // One count step in the given mode; split mode steps the low byte only
    function automatic dmut_count_type dmut_step(input logic [1:0] mode,
                                                 input logic [7:0] hi,
                                                 input logic [7:0] lo);
        dmut_count_type r;
        r.ovf = 1'b0;
        r.hi = hi;
        r.lo = lo;
        unique case (mode)
            `DMUT_MODE_13: begin
                // Upper three low bits stay as they are
                r.lo[4:0] = lo[4:0] + 5'h01;
                if (lo[4:0] == 5'h1F) begin
                    r.hi = hi + 8'h01;
                    r.ovf = (hi == 8'hFF);
                end
            end
            `DMUT_MODE_16: begin
                {r.hi, r.lo} = {hi, lo} + 16'h0001;
                r.ovf = ({hi, lo} == 16'hFFFF);
            end
            `DMUT_MODE_RELOAD: begin
                r.lo = lo + 8'h01;
                if (lo == 8'hFF) begin
                    r.lo = hi;
                    r.ovf = 1'b1;
                end
            end
            `DMUT_MODE_SPLIT: begin
                r.lo = lo + 8'h01;
                r.ovf = (lo == 8'hFF);
            end
        endcase
        return r;
    endfunction : dmut_step

    // Low prescaler bits that must all be ones for a tick: 000 -> 128, 111 -> 1
    function automatic logic [6:0] dmut_presc_mask(input logic [2:0] sel);
        return 7'h7F >> sel;
    endfunction : dmut_presc_mask

endpackage : dmut_pkg

/* File: dmut_prescale.sv */
// Tick generator: fcpu/12 and the two oscillator prescalers
`timescale 1ns/1ps
`include "dmut_map.svh"
module dmut_prescale import dmut_pkg::*; #(
    parameter int CPU_DIV = 4,
    parameter int OSC_DIV = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Prescaler settings
    input wire logic [2:0] sel_first,
    input wire logic [2:0] sel_second,
    // One-cycle ticks
    output logic cpu12_tick,
    output logic presc_first_tick,
    output logic presc_second_tick
);
    localparam int CW = $clog2((CPU_DIV > OSC_DIV ? CPU_DIV : OSC_DIV) + 1);

    typedef struct packed {
        logic [CW-1:0] cpu_cnt;
        logic [CW-1:0] osc_cnt;
        logic [3:0] div12;
        logic [6:0] presc;
        logic t12;
        logic tp0;
        logic tp1;
    } dmut_pre_state_type;

    dmut_pre_state_type q;
    dmut_pre_state_type d;
    logic cpu_tick;
    logic osc_tick;

    if (CPU_DIV < 1 || OSC_DIV < 1) begin : g_bad_div
        $error("dmut_prescale dividers must be at least one");
    end

    always_comb begin
        d = q;
        cpu_tick = (q.cpu_cnt == CW'(CPU_DIV - 1));
        osc_tick = (q.osc_cnt == CW'(OSC_DIV - 1));
        d.cpu_cnt = cpu_tick ? '0 : q.cpu_cnt + CW'(1);
        d.osc_cnt = osc_tick ? '0 : q.osc_cnt + CW'(1);
        d.t12 = cpu_tick && (q.div12 == 4'(`DMUT_CPU_PRESCALE - 1));
        if (cpu_tick) begin
            d.div12 = d.t12 ? 4'h0 : q.div12 + 4'h1;
        end
        if (osc_tick) begin
            d.presc = q.presc + 7'h01;
        end
        // One free counter serves both prescalers, so they stay in phase
        d.tp0 = osc_tick && ((q.presc & dmut_presc_mask(sel_first))
                             == dmut_presc_mask(sel_first));
        d.tp1 = osc_tick && ((q.presc & dmut_presc_mask(sel_second))
                             == dmut_presc_mask(sel_second));
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cpu12_tick = q.t12;
    assign presc_first_tick = q.tp0;
    assign presc_second_tick = q.tp1;

endmodule : dmut_prescale

/* File: dmut_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module dmut_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Pins and filtered levels
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } dmut_sync_state_type;

    dmut_sync_state_type q;
    dmut_sync_state_type d;

    if (W < 1) begin : g_bad_width
        $error("dmut_sync needs at least one pin");
    end

    always_comb begin
        d = q;
        d.s1 = pin_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // Agreeing stages set the level, a disagreement holds it
        d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level_out = q.lvl;

endmodule : dmut_sync

/* File: dmut_top.sv */
// Dual up-counting timers with an AXI4-Lite register slave
// Operation
// - Second overflow sets control bit seven
// - First overflow sets control bit five
// - Flags clear on service or software zero
// - Global enable bit seven gates all requests
// - First prescaler: 000 /128 down to /1
// - Second prescaler: 000 /128 down to /1
// - Second gate bit gates by pin b
// - First gate bit gates by pin a
// - Second select: fcpu/12 or prescaled oscillator
// - First select: fcpu/12 or prescaled oscillator
// - Second modes: 13, 16, reload; 11 reserved
// - First modes: 13, 16, reload, split
// - High bytes read/write, reset zero
// - Low bytes read/write, reset zero
// - 13-bit wraps 0xFF1F to zero, flags
// - Reload mode copies high byte on wrap
// - Split: high byte on fcpu/12, second run
// - Flag requests only when its enable set
`timescale 1ns/1ps
`include "dmut_map.svh"
module dmut_top import dmut_pkg::*; #(
    parameter int CPU_DIV = 4,
    parameter int OSC_DIV = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // External interrupt pins used for gating
    input wire logic ext_int_pin_a,
    input wire logic ext_int_pin_b,
    // Interrupt controller
    input wire logic irq_ack_first,
    input wire logic irq_ack_second,
    output logic irq_first_req,
    output logic irq_second_req,
    // AXI4-Lite write
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ================================================================
    // Declarations
    dmut_state_type q;
    dmut_state_type d;
    logic [1:0] pin_lvl;
    logic cpu12_tick;
    logic presc0_tick;
    logic presc1_tick;
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic split;
    logic en0;
    logic en0_hi;
    logic en1;
    logic ovf0_ev;
    logic ovf1_ev;
    dmut_count_type s0;
    dmut_count_type s0_hi;
    dmut_count_type s1;
    logic wr_en;
    logic [7:0] wr_idx;
    logic [7:0] wb;
    logic [7:0] rd_idx;
    logic [7:0] rb;
    logic rd_hit;
    logic wr_hit;

    // ================================================================
    // Pin synchroniser and tick generator
    dmut_sync #(
        .W(2)
    ) dmut_sync_inst (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_in({ext_int_pin_b, ext_int_pin_a}),
        .level_out(pin_lvl)
    );

    dmut_prescale #(
        .CPU_DIV(CPU_DIV),
        .OSC_DIV(OSC_DIV)
    ) dmut_prescale_inst (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .sel_first(q.presc0),
        .sel_second(q.presc1),
        .cpu12_tick(cpu12_tick),
        .presc_first_tick(presc0_tick),
        .presc_second_tick(presc1_tick)
    );

    // ================================================================
    // Count enables and steps
    always_comb begin
        mode0 = q.timer_mode_select[`DMUT_FIRST_MODE_LSB +: 2];
        mode1 = q.timer_mode_select[`DMUT_SECOND_MODE_LSB +: 2];
        split = (mode0 == `DMUT_MODE_SPLIT);
        en0 = q.tr0
              && (!q.timer_mode_select[`DMUT_FIRST_GATE_BIT] || pin_lvl[0])
              && (q.timer_mode_select[`DMUT_FIRST_CSEL_BIT] ? presc0_tick : cpu12_tick);
        // Reserved code 11 stops the second timer
        en1 = q.tr1 && (mode1 != `DMUT_MODE_SPLIT)
              && (!q.timer_mode_select[`DMUT_SECOND_GATE_BIT] || pin_lvl[1])
              && (q.timer_mode_select[`DMUT_SECOND_CSEL_BIT] ? presc1_tick : cpu12_tick);
        en0_hi = split && q.tr1 && cpu12_tick;
        s0 = dmut_step(mode0, q.th0, q.tl0);
        s0_hi = dmut_step(`DMUT_MODE_SPLIT, 8'h00, q.th0);
        s1 = dmut_step(mode1, q.th1, q.tl1);
        ovf0_ev = en0 && s0.ovf;
        // In split mode the second flag belongs to the first timer's high byte
        ovf1_ev = split ? (en0_hi && s0_hi.ovf) : (en1 && s1.ovf);
    end

    // ================================================================
    // Register read decode
    always_comb begin
        rd_idx = s_axi_araddr[9:2];
        rd_hit = 1'b1;
        rb = 8'h00;
        unique case (rd_idx)
            `DMUT_IDX_CTRL_STATUS: begin
                rb[`DMUT_SECOND_FLAG_BIT] = q.tf1;
                rb[`DMUT_SECOND_RUN_BIT] = q.tr1;
                rb[`DMUT_FIRST_FLAG_BIT] = q.tf0;
                rb[`DMUT_FIRST_RUN_BIT] = q.tr0;
            end
            `DMUT_IDX_MODE_SEL: rb = q.timer_mode_select;
            `DMUT_IDX_FIRST_LOW: rb = q.tl0;
            `DMUT_IDX_SECOND_LOW: rb = q.tl1;
            `DMUT_IDX_FIRST_HIGH: rb = q.th0;
            `DMUT_IDX_SECOND_HIGH: rb = q.th1;
            `DMUT_IDX_IRQ_ENABLE: begin
                rb[`DMUT_GLOBAL_IE_BIT] = q.global_irq_enable;
                rb[`DMUT_SECOND_IE_BIT] = q.et1;
                rb[`DMUT_FIRST_IE_BIT] = q.et0;
            end
            `DMUT_IDX_PRESCALER: begin
                rb[`DMUT_FIRST_PRESC_LSB +: 3] = q.presc0;
                rb[`DMUT_SECOND_PRESC_LSB +: 3] = q.presc1;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // ================================================================
    // Next state
    always_comb begin
        d = q;
        wr_idx = s_axi_awaddr[9:2];
        wb = s_axi_wdata[7:0];
        wr_hit = 1'b1;
        unique case (wr_idx)
            `DMUT_IDX_CTRL_STATUS, `DMUT_IDX_MODE_SEL, `DMUT_IDX_FIRST_LOW,
            `DMUT_IDX_SECOND_LOW, `DMUT_IDX_FIRST_HIGH, `DMUT_IDX_SECOND_HIGH,
            `DMUT_IDX_IRQ_ENABLE, `DMUT_IDX_PRESCALER: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
        // Address and data are both held by the master until taken here
        wr_en = (q.wst == DMUT_TAKE) && s_axi_wstrb[0] && wr_hit;

        // Counting first, so a software write in the same cycle wins
        if (en0) begin
            d.tl0 = s0.lo;
            if (!split) begin
                d.th0 = s0.hi;
            end
        end
        if (en0_hi) begin
            d.th0 = s0_hi.lo;
        end
        if (en1) begin
            d.th1 = s1.hi;
            d.tl1 = s1.lo;
        end

        if (wr_en) begin
            unique case (wr_idx)
                `DMUT_IDX_CTRL_STATUS: begin
                    d.tf1 = wb[`DMUT_SECOND_FLAG_BIT];
                    d.tr1 = wb[`DMUT_SECOND_RUN_BIT];
                    d.tf0 = wb[`DMUT_FIRST_FLAG_BIT];
                    d.tr0 = wb[`DMUT_FIRST_RUN_BIT];
                end
                `DMUT_IDX_MODE_SEL: d.timer_mode_select = wb;
                `DMUT_IDX_FIRST_LOW: d.tl0 = wb;
                `DMUT_IDX_SECOND_LOW: d.tl1 = wb;
                `DMUT_IDX_FIRST_HIGH: d.th0 = wb;
                `DMUT_IDX_SECOND_HIGH: d.th1 = wb;
                `DMUT_IDX_IRQ_ENABLE: begin
                    d.global_irq_enable = wb[`DMUT_GLOBAL_IE_BIT];
                    d.et1 = wb[`DMUT_SECOND_IE_BIT];
                    d.et0 = wb[`DMUT_FIRST_IE_BIT];
                end
                `DMUT_IDX_PRESCALER: begin
                    d.presc0 = wb[`DMUT_FIRST_PRESC_LSB +: 3];
                    d.presc1 = wb[`DMUT_SECOND_PRESC_LSB +: 3];
                end
                default: d.timer_mode_select = q.timer_mode_select;
            endcase
        end

        // Service clears the flag, but an overflow in the same cycle wins
        if (irq_ack_first) begin
            d.tf0 = 1'b0;
        end
        if (irq_ack_second) begin
            d.tf1 = 1'b0;
        end
        if (ovf0_ev) begin
            d.tf0 = 1'b1;
        end
        if (ovf1_ev) begin
            d.tf1 = 1'b1;
        end

        d.irq0 = q.tf0 && q.et0 && q.global_irq_enable;
        d.irq1 = q.tf1 && q.et1 && q.global_irq_enable;

        // Write channel: wait for both, take both, answer
        unique case (q.wst)
            DMUT_IDLE: begin
                if (s_axi_awvalid && s_axi_wvalid) begin
                    d.awready = 1'b1;
                    d.wready = 1'b1;
                    d.wst = DMUT_TAKE;
                end
            end
            DMUT_TAKE: begin
                d.awready = 1'b0;
                d.wready = 1'b0;
                d.bvalid = 1'b1;
                d.bresp = wr_hit ? `DMUT_RESP_OKAY : `DMUT_RESP_SLVERR;
                d.wst = DMUT_RESP;
            end
            DMUT_RESP: begin
                if (s_axi_bready) begin
                    d.bvalid = 1'b0;
                    d.wst = DMUT_IDLE;
                end
            end
            default: d.wst = DMUT_IDLE;
        endcase

        // Read channel
        unique case (q.rst)
            DMUT_IDLE: begin
                if (s_axi_arvalid) begin
                    d.arready = 1'b1;
                    d.rst = DMUT_TAKE;
                end
            end
            DMUT_TAKE: begin
                d.arready = 1'b0;
                d.rvalid = 1'b1;
                d.rdata = {24'h000000, rb};
                d.rresp = rd_hit ? `DMUT_RESP_OKAY : `DMUT_RESP_SLVERR;
                d.rst = DMUT_RESP;
            end
            DMUT_RESP: begin
                if (s_axi_rready) begin
                    d.rvalid = 1'b0;
                    d.rst = DMUT_IDLE;
                end
            end
            default: d.rst = DMUT_IDLE;
        endcase
    end

    // All fields, counters at 0x00 included, reset to zero
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ================================================================
    // Outputs
    assign irq_first_req = q.irq0;
    assign irq_second_req = q.irq1;
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;

    // ================================================================
    // Assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    property p_second_flag_set;
        ovf1_ev |=> q.tf1;
    endproperty
    a_second_flag_set: assert property (p_second_flag_set)
        else $error("second overflow did not set its flag");

    property p_first_flag_set;
        ovf0_ev |=> q.tf0;
    endproperty
    a_first_flag_set: assert property (p_first_flag_set)
        else $error("first overflow did not set its flag");

    property p_service_clear;
        irq_ack_first && !ovf0_ev |=> !q.tf0 ##1 !irq_first_req;
    endproperty
    a_service_clear: assert property (p_service_clear)
        else $error("serviced first flag not cleared");

    property p_global_gate;
        !q.global_irq_enable |=> !irq_first_req && !irq_second_req;
    endproperty
    a_global_gate: assert property (p_global_gate)
        else $error("request raised with global enable off");

    property p_forward;
        q.tf1 && q.et1 && q.global_irq_enable |=> irq_second_req;
    endproperty
    a_forward: assert property (p_forward)
        else $error("enabled second flag not forwarded");

    property p_hold_stopped;
        !q.tr0 && !split && !wr_en |=> $stable({q.th0, q.tl0});
    endproperty
    a_hold_stopped: assert property (p_hold_stopped)
        else $error("stopped first timer changed");

    property p_pin_gate;
        q.timer_mode_select[`DMUT_FIRST_GATE_BIT] && !pin_lvl[0] && !wr_en |=> $stable(q.tl0);
    endproperty
    a_pin_gate: assert property (p_pin_gate)
        else $error("gated first timer counted");

    property p_wrap13;
        en0 && mode0 == `DMUT_MODE_13 && q.th0 == 8'hFF && q.tl0[4:0] == 5'h1F
        && !wr_en |=> q.th0 == 8'h00 && q.tl0[4:0] == 5'h00 && q.tf0;
    endproperty
    a_wrap13: assert property (p_wrap13)
        else $error("13-bit wrap wrong");

    property p_reload;
        en1 && mode1 == `DMUT_MODE_RELOAD && q.tl1 == 8'hFF && !split && !wr_en
        |=> q.tl1 == $past(q.th1) && q.tf1;
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload did not copy the high byte");

    property p_split_high;
        split && !q.tr1 && !wr_en |=> $stable(q.th0);
    endproperty
    a_split_high: assert property (p_split_high)
        else $error("split high byte ran without second run bit");

    property p_write_answer;
        s_axi_awvalid && s_axi_wvalid && q.wst == DMUT_IDLE |-> ##2 s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write response late");

    c_first_overflow: cover property (ovf0_ev && mode0 == `DMUT_MODE_16);
    c_reload_wrap: cover property (ovf1_ev && mode1 == `DMUT_MODE_RELOAD);
    c_split_both: cover property (split && ovf0_ev ##[1:300] ovf1_ev);
    c_ack_race: cover property (irq_ack_first && ovf0_ev);

endmodule : dmut_top

/* File: tb_dmut_top.sv */
// Self-checking bench for the dual up timers over the register bus
`timescale 1ns/1ps
module tb_dmut_top;
// ================================================================
// Signals
logic clk_sys, sys_rst, pin_a, ack_a, irq_a, pin_b, ack_b, irq_b;
logic [9:0] awaddr, araddr;
logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
logic [31:0] wdata, rdata, v, v0;
logic [1:0] bresp, rresp;
logic [7:0] regs [8] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hA8, 8'hE7};
int num_errors = 0;
int samples_checked = 0;

// Fast ticks keep the run short: fcpu/12 every 12 cycles, fosc every cycle
dmut_top #(.CPU_DIV(1), .OSC_DIV(1)) dmut_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .ext_int_pin_a(pin_a), .ext_int_pin_b(pin_b), .irq_ack_first(ack_a),
    .irq_ack_second(ack_b), .irq_first_req(irq_a), .irq_second_req(irq_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

// ================================================================
// Tasks
task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
        num_errors++;
        $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
endtask : check

task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask : print_verdict

// Each bus task ends one edge late so the next request never lands in the same step
task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic [1:0] er);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk_sys); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", {30'h0, bresp}, {30'h0, er});
    @(posedge clk_sys);
endtask : wr

task automatic rd(input logic [7:0] idx, input logic [1:0] er);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    rready <= 1'b0;
    v = rdata;
    check("rresp", {30'h0, rresp}, {30'h0, er});
    @(posedge clk_sys);
endtask : rd

task automatic rdx(input logic [7:0] idx, input logic [7:0] exp);
    rd(idx, 2'h0);
    check("rdata", v, {24'h0, exp});
endtask : rdx

// ================================================================
// Clock, watchdog, tests
initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
end

initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
end

initial begin
    {sys_rst, pin_a, ack_a, pin_b, ack_b} <= 5'h10;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
    {awaddr, araddr, wdata} <= '0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    foreach (regs[i]) rdx(regs[i], 8'h00);
    for (int i = 2; i < 6; i++) begin
        wr(regs[i], ~regs[i], 2'h0);
        rdx(regs[i], ~regs[i]);
        wr(regs[i], 8'h00, 2'h0);
    end
    wr(8'hE7, 8'hFF, 2'h0);
    rdx(8'hE7, 8'h77);
    wr(8'h88, 8'h0F, 2'h0);
    rdx(8'h88, 8'h00);
    wr(8'h90, 8'h11, 2'h2);
    rd(8'h90, 2'h2);
    // Rates: first on fosc/2, second on fcpu/12, both 16-bit
    wr(8'hE7, 8'h60, 2'h0);
    wr(8'h89, 8'h15, 2'h0);
    wr(8'h88, 8'h50, 2'h0);
    repeat (240) @(posedge clk_sys);
    wr(8'h88, 8'h00, 2'h0);
    rd(8'h8A, 2'h0);
    v0 = v;
    check("tl0_rate", {31'h0, v >= 32'h73 && v <= 32'h82}, 1);
    rd(8'h8B, 2'h0);
    check("tl1_rate", {31'h0, v >= 32'h12 && v <= 32'h17}, 1);
    rdx(8'h8A, v0[7:0]);
    // Gated 16-bit overflow of the first timer
    wr(8'hE7, 8'h70, 2'h0);
    wr(8'h89, 8'h0D, 2'h0);
    wr(8'h8C, 8'hFF, 2'h0);
    wr(8'h8A, 8'hF0, 2'h0);
    wr(8'h88, 8'h10, 2'h0);
    repeat (40) @(posedge clk_sys);
    rdx(8'h88, 8'h10);
    pin_a <= 1'b1;
    repeat (40) @(posedge clk_sys);
    rdx(8'h88, 8'h30);
    wr(8'hA8, 8'h82, 2'h0);
    repeat (3) @(posedge clk_sys);
    check("irq_on", {31'h0, irq_a}, 1);
    wr(8'hA8, 8'h02, 2'h0);
    repeat (3) @(posedge clk_sys);
    check("irq_gated", {31'h0, irq_a}, 0);
    wr(8'hA8, 8'h82, 2'h0);
    ack_a <= 1'b1;
    @(posedge clk_sys);
    ack_a <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rdx(8'h88, 8'h10);
    check("irq_off", {31'h0, irq_a}, 0);
    // 13-bit wrap: upper low bits stay, high byte wraps to zero
    wr(8'h88, 8'h00, 2'h0);
    wr(8'h89, 8'h04, 2'h0);
    wr(8'h8C, 8'hFF, 2'h0);
    wr(8'h8A, 8'hE0, 2'h0);
    wr(8'h88, 8'h10, 2'h0);
    repeat (10) @(posedge clk_sys);
    rdx(8'h88, 8'h10);
    repeat (30) @(posedge clk_sys);
    rdx(8'h88, 8'h30);
    wr(8'h88, 8'h00, 2'h0);
    rd(8'h8A, 2'h0);
    check("tl0_top", {29'h0, v[7:5]}, 32'h7);
    rdx(8'h8C, 8'h00);
    // Reload mode on the second timer at fosc/1
    wr(8'hE7, 8'h07, 2'h0);
    wr(8'h89, 8'h60, 2'h0);
    wr(8'h8D, 8'hF0, 2'h0);
    wr(8'h8B, 8'hFA, 2'h0);
    wr(8'h88, 8'h40, 2'h0);
    repeat (20) @(posedge clk_sys);
    rdx(8'h88, 8'hC0);
    wr(8'h88, 8'h00, 2'h0);
    rdx(8'h88, 8'h00);
    rd(8'h8B, 2'h0);
    check("tl1_reload", {31'h0, v >= 32'hF0}, 1);
    rdx(8'h8D, 8'hF0);
    // Split mode: high byte runs on fcpu/12 under the second run bit and flag,
    // while the reserved code holds the second timer still
    wr(8'h8B, 8'h10, 2'h0);
    wr(8'h8C, 8'hF8, 2'h0);
    wr(8'hA8, 8'h8A, 2'h0);
    wr(8'h89, 8'h73, 2'h0);
    wr(8'h88, 8'h40, 2'h0);
    repeat (120) @(posedge clk_sys);
    rdx(8'h88, 8'hC0);
    rdx(8'h8B, 8'h10);
    check("irq_second_on", {31'h0, irq_b}, 1);
    ack_b <= 1'b1;
    @(posedge clk_sys);
    ack_b <= 1'b0;
    rdx(8'h88, 8'h40);
    check("irq_second_off", {31'h0, irq_b}, 0);
    // Second timer in 16-bit mode, gated by pin b
    wr(8'h88, 8'h00, 2'h0);
    wr(8'h89, 8'hD1, 2'h0);
    wr(8'h88, 8'h40, 2'h0);
    repeat (20) @(posedge clk_sys);
    rdx(8'h8B, 8'h10);
    pin_b <= 1'b1;
    repeat (20) @(posedge clk_sys);
    wr(8'h88, 8'h00, 2'h0);
    rd(8'h8B, 2'h0);
    check("tl1_ungated", {31'h0, v >= 32'h18 && v <= 32'h30}, 1);
    print_verdict();
end

endmodule : tb_dmut_top
